// >>> pkg/flash_prot_pkg.sv
// Constants and types for the flash protection gate
package flash_prot_pkg;
    localparam int unsigned FLASH_BYTES      = 131072;
    localparam int unsigned WORD_BYTES       = 4;
    localparam int unsigned FLASH_WORDS      = FLASH_BYTES / WORD_BYTES;
    localparam int unsigned ADDR_W           = 15;
    localparam int unsigned DATA_W           = 32;
    localparam int unsigned BLOCK_BYTES      = 1024;
    localparam int unsigned BLOCK_WORDS      = BLOCK_BYTES / WORD_BYTES;
    localparam int unsigned BLOCK_LSB        = 8;
    localparam int unsigned NUM_BLOCKS       = FLASH_BYTES / BLOCK_BYTES;
    localparam int unsigned BLOCK_W          = 7;
    localparam int unsigned UNIT_LSB         = 9;
    localparam int unsigned NUM_UNITS        = NUM_BLOCKS / 2;
    localparam int unsigned UNIT_W           = 6;
    localparam logic [7:0]  ERASE_LAST       = 8'hff;
    localparam logic [31:0] ERASED_WORD      = 32'hffffffff;
    localparam logic [31:0] DENIED_WORD      = 32'h00000000;

    typedef enum logic [1:0] {
        PROT_NONE  = 2'h0,
        PROT_RONLY = 2'h1,
        PROT_XONLY = 2'h2
    } prot_mode_t;

    typedef enum logic [1:0] {
        SRC_FETCH = 2'h0,
        SRC_DATA  = 2'h1,
        SRC_DEBUG = 2'h2
    } src_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ERASE = 3'b010,
        ST_READ  = 3'b100
    } state_t;
endpackage : flash_prot_pkg

// >>> hw/flash_array.sv
// Flash word array with registered read data
`timescale 1ns/1ps
module flash_array
    import flash_prot_pkg::*;
(
    // Clock
    input  wire logic              sys_clk,
    // Write port
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] waddr,
    input  wire logic [DATA_W-1:0] wdata,
    // Read port
    input  wire logic [ADDR_W-1:0] raddr,
    output logic      [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] mem [FLASH_WORDS];

    // No reset: contents model non-volatile storage
    always_ff @(posedge sys_clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : flash_array

// >>> hw/flash_block_protection.sv
// Flash access gate: per-block erase, per-pair protection
// Operation
// RULE1: 128 KB flash, 1 KB blocks erased independently
// RULE2: Erased block reads back all ones
// RULE3: Protection unit is a pair of blocks
// RULE4: Each unit unprotected, read-only or execute-only
// RULE5: Read-only unit refuses erase and program
// RULE6: Execute-only unit refuses erase and program
// RULE7: Execute-only unit readable only by instruction fetch
// RULE8: Denied read gives fixed value; refusal flags error
`timescale 1ns/1ps
module flash_block_protection
    import flash_prot_pkg::*;
(
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    // Protection setting, two bits per unit
    input  wire logic [2*NUM_UNITS-1:0] prot_cfg,
    // Read request
    input  wire logic                  rd_req,
    input  wire logic [1:0]            rd_src,
    input  wire logic [ADDR_W-1:0]     rd_addr,
    // Program request
    input  wire logic                  pgm_req,
    input  wire logic [ADDR_W-1:0]     pgm_addr,
    input  wire logic [DATA_W-1:0]     pgm_data,
    // Erase request
    input  wire logic                  ers_req,
    input  wire logic [BLOCK_W-1:0]    ers_block,
    // Answers
    output logic                       busy,
    output logic                       rd_valid,
    output logic                       rd_denied,
    output logic [DATA_W-1:0]          rd_data,
    output logic                       op_done,
    output logic                       op_error
);
    state_t             state_r;
    state_t             state_nxt;
    logic [BLOCK_W-1:0] ers_blk_r;
    logic [7:0]         ers_idx_r;
    logic               deny_r;

    // Unit decode of each target
    wire [UNIT_W-1:0] rd_unit   = rd_addr[ADDR_W-1:UNIT_LSB];                     // RULE3
    wire [UNIT_W-1:0] pgm_unit  = pgm_addr[ADDR_W-1:UNIT_LSB];                    // RULE3
    wire [UNIT_W-1:0] ers_unit  = ers_block[BLOCK_W-1:1];                         // RULE3
    wire [1:0]        rd_mode   = prot_cfg[2*rd_unit +: 2];                       // RULE4
    wire [1:0]        pgm_mode  = prot_cfg[2*pgm_unit +: 2];                      // RULE4
    wire [1:0]        ers_mode  = prot_cfg[2*ers_unit +: 2];                      // RULE4
    // Any mode other than unprotected locks out modification
    wire              pgm_lock  = (pgm_mode != PROT_NONE);                        // RULE5
    wire              ers_lock  = (ers_mode != PROT_NONE);                        // RULE6
    wire              rd_block  = (rd_mode == PROT_XONLY) && (rd_src != SRC_FETCH); // RULE7

    wire idle     = (state_r == ST_IDLE);
    // Erase has priority over program, program over read
    wire take_ers = idle && ers_req;
    wire take_pgm = idle && !ers_req && pgm_req;
    wire take_rd  = idle && !ers_req && !pgm_req && rd_req;
    wire ers_go   = take_ers && !ers_lock;
    wire pgm_go   = take_pgm && !pgm_lock;
    wire refuse   = (take_ers && ers_lock) || (take_pgm && pgm_lock);             // RULE8
    wire ers_last = (state_r == ST_ERASE) && (ers_idx_r == ERASE_LAST);

    // Array write: erase sweeps one block word by word
    wire              arr_we    = pgm_go || (state_r == ST_ERASE);                // RULE1
    wire [ADDR_W-1:0] arr_waddr = (state_r == ST_ERASE) ? {ers_blk_r, ers_idx_r} : pgm_addr; // RULE1
    wire [DATA_W-1:0] arr_wdata = (state_r == ST_ERASE) ? ERASED_WORD : pgm_data; // RULE2
    wire [DATA_W-1:0] arr_rdata;

    flash_array u_array (
        .sys_clk (sys_clk),
        .we      (arr_we),
        .waddr   (arr_waddr),
        .wdata   (arr_wdata),
        .raddr   (rd_addr),
        .rdata   (arr_rdata)
    );

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
            begin
                if (ers_go)
                    state_nxt = ST_ERASE;
                else if (take_rd)
                    state_nxt = ST_READ;
            end
            ST_ERASE:
            begin
                if (ers_last)
                    state_nxt = ST_IDLE;
            end
            ST_READ:
                state_nxt = ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r   <= ST_IDLE;
            ers_blk_r <= '0;
            ers_idx_r <= '0;
            deny_r    <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (ers_go)
            begin
                ers_blk_r <= ers_block;
                ers_idx_r <= '0;
            end
            else if (state_r == ST_ERASE)
            begin
                ers_idx_r <= ers_idx_r + 8'h01;
            end
            if (take_rd)
            begin
                deny_r <= rd_block;
            end
        end
    end

    // Outputs registered; data comes a cycle after the array read
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            busy      <= 1'b0;
            rd_valid  <= 1'b0;
            rd_denied <= 1'b0;
            rd_data   <= '0;
            op_done   <= 1'b0;
            op_error  <= 1'b0;
        end
        else
        begin
            busy      <= (state_nxt != ST_IDLE);
            rd_valid  <= (state_r == ST_READ);
            rd_denied <= (state_r == ST_READ) && deny_r;                          // RULE7
            // Stored word never leaves on a denied read
            rd_data   <= (state_r != ST_READ) ? '0 : (deny_r ? DENIED_WORD : arr_rdata); // RULE8
            op_done   <= pgm_go || ers_last || refuse;
            op_error  <= refuse;                                                  // RULE8
        end
    end

    AST_RONLY_PGM_REFUSED: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE5
        (take_pgm && pgm_mode == PROT_RONLY) |=> (op_done && op_error))
        else $error("Read-only program not refused");

    AST_XONLY_ERS_REFUSED: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE6
        (take_ers && ers_mode == PROT_XONLY) |=> (op_error && state_r == ST_IDLE))
        else $error("Execute-only erase not refused");

    // Judged from the written address and the raw setting bits, not from the lock decode
    AST_LOCK_NO_WRITE: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE5
        (idle && arr_we) |-> (!prot_cfg[{arr_waddr[ADDR_W-1:UNIT_LSB], 1'b0}]
                              && !prot_cfg[{arr_waddr[ADDR_W-1:UNIT_LSB], 1'b1}]))
        else $error("Write into protected unit");

    sequence s_erase_run;
        (state_r == ST_ERASE) [*8];
    endsequence

    AST_ERASE_ONES: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE2
        (state_r == ST_ERASE) |-> (arr_we && arr_wdata == ERASED_WORD && arr_waddr[ADDR_W-1:BLOCK_LSB] == ers_blk_r))
        else $error("Erase writes wrong value or block");

    AST_ERASE_LEN: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE1
        (ers_go ##1 s_erase_run) |-> ##249 (op_done && !op_error))
        else $error("Erase length wrong");

    AST_XONLY_DENY: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE7
        (take_rd && rd_mode == PROT_XONLY && rd_src != SRC_FETCH) |=> ##1 (rd_valid && rd_denied && rd_data == DENIED_WORD))
        else $error("Execute-only data read not denied");

    AST_FETCH_OK: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE7
        (take_rd && rd_src == SRC_FETCH) |=> ##1 (rd_valid && !rd_denied))
        else $error("Fetch read wrongly denied");

    AST_UNIT_PAIR: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE3
        take_ers |-> (ers_lock == (prot_cfg[{ers_block[BLOCK_W-1:1], 1'b1}]
                                   || prot_cfg[{ers_block[BLOCK_W-1:1], 1'b0}])))
        else $error("Unit decode wrong");

    AST_MODE_ALLOW: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4
        (take_pgm && pgm_mode == PROT_NONE) |=> (op_done && !op_error && $past(arr_we)))
        else $error("Unprotected program refused");
endmodule : flash_block_protection

// >>> tb/read_requester.sv
// Requester model: raises a read and holds it until the design takes it at an idle edge
`timescale 1ns/1ps
module read_requester
    import flash_prot_pkg::*;
(
    // Control
    input  wire logic              sys_clk,
    input  wire logic              go,
    input  wire logic [1:0]        src_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    // Read port
    input  wire logic              busy,
    input  wire logic              rd_valid,
    output logic                   rd_req = 1'b0,
    output logic      [1:0]        rd_src = 2'h0,
    output logic      [ADDR_W-1:0] rd_addr = 15'h0000
);
    // Requests made while busy are ignored, so hold until taken at an idle edge;
    // holding on to the answer would let the idle design take the same read twice
    always @(posedge sys_clk)
    begin
        if (go)
        begin
            rd_req  <= 1'b1;
            rd_src  <= src_in;
            rd_addr <= addr_in;
        end
        else if ((rd_req && !busy) || rd_valid)
            rd_req <= 1'b0;
    end
endmodule : read_requester

// >>> tb/flash_block_protection_bench.sv
// Bench for the flash protection gate
`timescale 1ns/1ps
module flash_block_protection_bench;
    import flash_prot_pkg::*;
    logic                   sys_clk, rstn, pgm_req, ers_req, go;
    logic [2*NUM_UNITS-1:0] prot_cfg;
    logic [ADDR_W-1:0]      pgm_addr, addr, rd_addr;
    logic [DATA_W-1:0]      pgm_data, rd_data;
    logic [BLOCK_W-1:0]     ers_block;
    logic [1:0]             src, rd_src;
    logic                   rd_req, busy, rd_valid, rd_denied, op_done, op_error;
    int                     failures = 0;
    int                     samples_checked = 0;
    flash_block_protection dut (.sys_clk(sys_clk), .rstn(rstn), .prot_cfg(prot_cfg), .rd_req(rd_req),
        .rd_src(rd_src), .rd_addr(rd_addr), .pgm_req(pgm_req), .pgm_addr(pgm_addr), .pgm_data(pgm_data),
        .ers_req(ers_req), .ers_block(ers_block), .busy(busy), .rd_valid(rd_valid),
        .rd_denied(rd_denied), .rd_data(rd_data), .op_done(op_done), .op_error(op_error));
    read_requester req (.sys_clk(sys_clk), .go(go), .src_in(src), .addr_in(addr), .busy(busy),
        .rd_valid(rd_valid), .rd_req(rd_req), .rd_src(rd_src), .rd_addr(rd_addr));
    task automatic wrap_up();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            failures++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : check
    // Outputs are read right at the edge, before that edge's updates land
    task automatic wait_for(input bit rd);
        int n;
        n = 0;
        while ((rd ? rd_valid : op_done) !== 1'b1)
        begin
            @(posedge sys_clk);
            n++;
            if (n > 400)
            begin
                failures++;
                wrap_up();
            end
        end
    endtask : wait_for
    task automatic pgm(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic e);
        @(posedge sys_clk);
        pgm_req  <= 1'b1;
        pgm_addr <= a;
        pgm_data <= d;
        // Taken at the first idle edge; holding longer would program twice
        @(posedge sys_clk);
        pgm_req <= 1'b0;
        wait_for(1'b0);
        check("pgm op_error", op_error, e);
        repeat (3) @(posedge sys_clk);
    endtask : pgm
    task automatic ers(input logic [BLOCK_W-1:0] b, input logic e);
        @(posedge sys_clk);
        ers_req   <= 1'b1;
        ers_block <= b;
        @(posedge sys_clk);
        ers_req <= 1'b0;
        @(posedge sys_clk);
        check("ers busy", busy, !e);
        wait_for(1'b0);
        check("ers op_error", op_error, e);
        check("ers busy end", busy, 1'b0);
        repeat (3) @(posedge sys_clk);
    endtask : ers
    task automatic rd(input logic [1:0] s, input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic d);
        @(posedge sys_clk);
        go   <= 1'b1;
        src  <= s;
        addr <= a;
        @(posedge sys_clk);
        go <= 1'b0;
        wait_for(1'b1);
        check("rd_data", rd_data, e);
        check("rd_denied", rd_denied, d);
        repeat (3) @(posedge sys_clk);
    endtask : rd
    task automatic t_erase();
        pgm(15'h000a, 32'h12345678, 1'b0);
        pgm(15'h0105, 32'h00000000, 1'b0);
        ers(7'h01, 1'b0);
        rd(SRC_FETCH, 15'h0105, ERASED_WORD, 1'b0);
        rd(SRC_DATA, 15'h000a, 32'h12345678, 1'b0);
        ers(7'h7f, 1'b0);
        rd(SRC_DEBUG, 15'h7fff, ERASED_WORD, 1'b0);
    endtask : t_erase
    task automatic t_ronly();
        pgm(15'h0200, 32'hcafe0001, 1'b0);
        prot_cfg[3:2] <= PROT_RONLY;
        pgm(15'h0200, 32'h00000000, 1'b1);
        ers(7'h03, 1'b1);
        pgm(15'h01ff, 32'h00000055, 1'b0);
        rd(SRC_DATA, 15'h0200, 32'hcafe0001, 1'b0);
        rd(SRC_DEBUG, 15'h0200, 32'hcafe0001, 1'b0);
    endtask : t_ronly
    task automatic t_xonly();
        pgm(15'h0400, 32'habcd0002, 1'b0);
        prot_cfg[5:4] <= PROT_XONLY;
        pgm(15'h0406, 32'h00000001, 1'b1);
        ers(7'h05, 1'b1);
        rd(SRC_FETCH, 15'h0400, 32'habcd0002, 1'b0);
        rd(SRC_DATA, 15'h0400, DENIED_WORD, 1'b1);
        rd(SRC_DEBUG, 15'h0400, DENIED_WORD, 1'b1);
        pgm(15'h0600, 32'h5a5a0003, 1'b0);
        prot_cfg[7:6] <= 2'h3;
        pgm(15'h0600, 32'h00000000, 1'b1);
        rd(SRC_DEBUG, 15'h0600, 32'h5a5a0003, 1'b0);
    endtask : t_xonly
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial
    begin
        {rstn, pgm_req, ers_req, go, src} = 6'h00;
        {prot_cfg, pgm_addr, pgm_data, ers_block, addr} = '0;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        t_erase();
        t_ronly();
        t_xonly();
        wrap_up();
    end
endmodule : flash_block_protection_bench
